// >>> hw/plrp_pkg.sv
`default_nettype none
package plrp_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Mode and pin function control
  localparam logic [7:0] ADDR_STATUS = 8'h04; // Live status, read only
  localparam logic [7:0] ADDR_STRAP = 8'h08; // Latched strap levels, read only

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0; // LED mode, two bits
  localparam int CTRL_DUP_BIT = 2; // Mode 3: show duplex instead of collision
  localparam int CTRL_IRQ_BIT = 3; // Shared pin acts as interrupt output
  localparam int CTRL_RMII_BIT = 4; // Reduced interface selected

  // ----------------------------------------
  // LED modes and reset values
  // ----------------------------------------
  localparam logic [1:0] LED_MODE_1 = 2'h1;
  localparam logic [1:0] LED_MODE_2 = 2'h2;
  localparam logic [1:0] LED_MODE_3 = 2'h3;
  localparam logic [1:0] LED_MODE_RST = 2'h1; // Before straps are taken
  localparam logic DUP_RST = 1'h0;
  localparam logic IRQ_FUNC_RST = 1'h0; // Power-down input after reset
  localparam logic RMII_RST = 1'h0;

  // ----------------------------------------
  // Clocking and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250; // System clock rate
  localparam int MII_OUT_MHZ = 25; // Reference output in MII operation
  localparam int RMII_OUT_MHZ = 50; // Reference output in RMII operation
  localparam logic [3:0] DIV_MII = 4'(CLK_MHZ / MII_OUT_MHZ);
  localparam logic [3:0] DIV_RMII = 4'(CLK_MHZ / RMII_OUT_MHZ);
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // Cycles after release before latch
  localparam int BLINK_HALF_MS = 50; // Off and on phase of one blink
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // Blink engine states
  typedef enum logic [1:0] {BLK_IDLE, BLK_OFF, BLK_ON} plrp_blink_st_t;

endpackage
`default_nettype wire

// >>> hw/plrp_if.sv
`default_nettype none
// Signals shared between the top and its two helpers
interface plrp_if;
  logic act; // Activity worth a blink
  logic blank; // Link indicator is blanked
  logic rmii_sel; // Reference output at RMII rate
  logic ref_clk; // Divided reference output
  modport blink (input act, output blank);
  modport clkgen (input rmii_sel, output ref_clk);
  modport top (output act, output rmii_sel, input blank, input ref_clk);
endinterface
`default_nettype wire

// >>> hw/plrp_clkgen.sv
`default_nettype none
// Reference clock output divider
module plrp_clkgen (
  input wire logic clk,
  input wire logic rst_n,
  plrp_if.clkgen lk
);

  logic [3:0] cnt_r; // Phase counter
  logic [3:0] cnt_nxt;
  logic out_r; // Registered clock output
  logic sel_r; // Rate in force for the running period
  logic [3:0] div; // Cycles per output period
  logic wrap;

  // Period follows the selection taken at the last wrap, so a change never stretches a phase
  assign div = sel_r ? plrp_pkg::DIV_RMII : plrp_pkg::DIV_MII;
  assign wrap = (cnt_r >= div - 4'h1);
  assign cnt_nxt = wrap ? 4'h0 : cnt_r + 4'h1;
  assign lk.ref_clk = out_r;

  // High for the first half of each period, rounded down: 5 of 10 cycles in MII, 2 of 5 in RMII
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      out_r <= 1'b0;
      sel_r <= plrp_pkg::RMII_RST;
    end else begin
      if (wrap) begin
        sel_r <= lk.rmii_sel;
      end
      cnt_r <= cnt_nxt;
      out_r <= (cnt_nxt < (div >> 1));
    end
  end

endmodule
`default_nettype wire

// >>> hw/plrp_blink.sv
`default_nettype none
// Link indicator blink engine: one off then on phase per burst
module plrp_blink #(
  parameter int HALF_CYC = plrp_pkg::BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  plrp_if.blink lk
);

  plrp_pkg::plrp_blink_st_t state_r, state_nxt; // Blink phase
  logic [23:0] cnt_r; // Phase time left
  logic pend_r; // Activity seen, blink owed
  logic blank_r; // Registered blanking
  logic start;
  logic done;

  assign done = (cnt_r == 24'h000000);
  assign start = (state_r == plrp_pkg::BLK_IDLE) && (pend_r || lk.act);
  assign lk.blank = blank_r;

  // Next phase
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      plrp_pkg::BLK_IDLE: if (start) state_nxt = plrp_pkg::BLK_OFF;
      plrp_pkg::BLK_OFF: if (done) state_nxt = plrp_pkg::BLK_ON;
      plrp_pkg::BLK_ON: if (done) state_nxt = plrp_pkg::BLK_IDLE;
      default: state_nxt = plrp_pkg::BLK_IDLE;
    endcase
  end

  // Fixed-period phases; new activity during a blink is owed one more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= plrp_pkg::BLK_IDLE;
      cnt_r <= 24'h000000;
      pend_r <= 1'b0;
      blank_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? 24'(HALF_CYC - 1) : cnt_r - {23'h0, ~done};
      pend_r <= (lk.act && !start) || (pend_r && !start);
      blank_r <= (state_nxt == plrp_pkg::BLK_OFF);
    end
  end

endmodule
`default_nettype wire

// >>> hw/plrp_top.sv
// Functional notes
// - MII: reference output runs at 25 MHz
// - RMII: reference output runs at 50 MHz
// - Mode 1: link LED shows link only
// - Modes 2,3: link LED blinks on activity
// - Speed LED on at 100, off 10
// - Mode 1: activity LED shows TX/RX activity
// - Mode 2: activity LED shows collision
// - Mode 3: setting selects duplex over collision
// - Reset held low 1 us resets all
// - Reset returns every register to default
// - Reset re-takes every strap option
// - Straps sampled at reset select modes
// - Shared pin is power-down input after reset
// - Pin low in input role powers down
// - Interrupt role: open drain, pulled low
// - Pin role changes only by register write
`default_nettype none
module plrp_top #(
  parameter int BLINK_HALF_CYC = plrp_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Status from the transceiver core
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  input wire logic COLLISION,
  input wire logic FULL_DUPLEX,
  input wire logic IRQ_REQ,
  // Strap pins
  input wire logic STRAP_RMII,
  input wire logic [1:0] STRAP_LED_MODE,
  // Shared power-down / interrupt pin
  input wire logic POWERDOWN_IRQ_PIN_I,
  output logic POWERDOWN_IRQ_PIN_O,
  output logic POWERDOWN_IRQ_PIN_OE,
  // Outputs
  output logic POWER_DOWN,
  output logic REF_CLOCK_OUT,
  output logic LINK_INDICATOR,
  output logic SPEED_INDICATOR,
  output logic ACTIVITY_COLLISION_INDICATOR
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Word address match against a register offset
  function automatic logic addr_is(input logic [31:0] addr, input logic [7:0] off);
    addr_is = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
  endfunction

  // Undefined mode value behaves as mode 1
  function automatic logic [1:0] mode_eff(input logic [1:0] m);
    mode_eff = (m == 2'h0) ? plrp_pkg::LED_MODE_1 : m;
  endfunction

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  plrp_if lk(); // Link to helper modules

  logic [1:0] mode_r; // LED mode
  logic dup_show_r; // Mode 3 duplex display
  logic irq_func_r; // Shared pin acts as interrupt
  logic rmii_sel_r; // RMII operation
  logic strap_done_r; // Straps taken since reset
  logic [1:0] settle_r; // Cycles since reset release
  logic [2:0] strap_val_r; // Latched strap levels
  logic [2:0] strap_s1_r; // Strap synchroniser, first stage
  logic [2:0] strap_s2_r; // Strap synchroniser, second stage
  logic pin_s1_r; // Pin synchroniser, first stage
  logic pin_s2_r; // Pin synchroniser, second stage
  logic wr_pend_r; // Write data phase pending
  logic wr_ctrl_r; // Pending write targets control
  logic [31:0] hrdata_r;
  logic link_led_r;
  logic speed_led_r;
  logic actcol_led_r;
  logic pd_r;
  logic pin_oe_r;
  logic pin_o_r;

  // ----------------------------------------
  // Decode and selection
  // ----------------------------------------
  logic addr_ph; // Valid address phase
  logic size_ok; // Word transfers only
  logic rd_ph; // Read address phase
  logic wr_ph; // Write address phase
  logic ctrl_wr; // Control write in data phase
  logic take_strap; // Strap latch moment
  logic [1:0] mode; // Effective LED mode
  logic is_mode1;
  logic is_mode3;
  logic act; // Transmit or receive activity
  logic link_nxt;
  logic actcol_nxt;
  logic pd_nxt;
  logic pin_oe_nxt;
  logic [31:0] ctrl_rd;
  logic [31:0] status_rd;
  logic [31:0] strap_rd;
  logic [31:0] rd_nxt;

  assign addr_ph = HSEL && HREADY && HTRANS[1];
  assign size_ok = (HSIZE == 3'h2);
  assign rd_ph = addr_ph && !HWRITE && size_ok;
  assign wr_ph = addr_ph && HWRITE && size_ok;
  // Writes before the straps are latched are dropped
  assign ctrl_wr = wr_pend_r && wr_ctrl_r && strap_done_r;
  assign take_strap = !strap_done_r && (settle_r == plrp_pkg::STRAP_SETTLE);

  assign mode = mode_eff(mode_r);
  assign is_mode1 = (mode == plrp_pkg::LED_MODE_1);
  assign is_mode3 = (mode == plrp_pkg::LED_MODE_3);
  assign act = TX_ACTIVE || RX_ACTIVE;

  // Blink only where the mode asks for it
  assign lk.act = act && LINK_UP && !is_mode1;
  assign lk.rmii_sel = rmii_sel_r;

  // Link indicator: on while link good, blanked by blink phase
  assign link_nxt = LINK_UP && (is_mode1 || !lk.blank);

  // Activity / collision / duplex selection
  assign actcol_nxt = is_mode1 ? act :
    (is_mode3 && dup_show_r) ? FULL_DUPLEX :
    COLLISION;

  // Pin low powers down only in input role
  assign pd_nxt = !irq_func_r && !pin_s2_r;
  // Open drain: enable only to pull low
  assign pin_oe_nxt = irq_func_r && IRQ_REQ;

  // Read views
  assign ctrl_rd = {27'h0, rmii_sel_r, irq_func_r, dup_show_r, mode_r};
  assign status_rd = {24'h0, strap_done_r, pin_oe_r, pd_r, FULL_DUPLEX,
                      COLLISION, act, SPEED_100, LINK_UP};
  assign strap_rd = {29'h0, strap_val_r};
  assign rd_nxt = !rd_ph ? 32'h00000000 :
    addr_is(HADDR, plrp_pkg::ADDR_CTRL) ? ctrl_rd :
    addr_is(HADDR, plrp_pkg::ADDR_STATUS) ? status_rd :
    addr_is(HADDR, plrp_pkg::ADDR_STRAP) ? strap_rd :
    32'h00000000;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------

  // Straps and shared pin come from outside the clock domain
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      strap_s1_r <= {STRAP_RMII, STRAP_LED_MODE};
      strap_s2_r <= strap_s1_r;
      pin_s1_r <= POWERDOWN_IRQ_PIN_I;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------

  // Let the synchronisers fill, then latch once per reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_val_r <= 3'h0;
    end else begin
      if (!strap_done_r && !take_strap) begin
        settle_r <= settle_r + 2'h1;
      end
      if (take_strap) begin
        strap_done_r <= 1'b1;
        strap_val_r <= strap_s2_r;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------

  // Straps seed modes; software may change them afterwards
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= plrp_pkg::LED_MODE_RST;
      dup_show_r <= plrp_pkg::DUP_RST;
      irq_func_r <= plrp_pkg::IRQ_FUNC_RST;
      rmii_sel_r <= plrp_pkg::RMII_RST;
    end else if (take_strap) begin
      mode_r <= strap_s2_r[1:0];
      rmii_sel_r <= strap_s2_r[2];
    end else if (ctrl_wr) begin
      mode_r <= HWDATA[plrp_pkg::CTRL_MODE_LSB +: 2];
      dup_show_r <= HWDATA[plrp_pkg::CTRL_DUP_BIT];
      irq_func_r <= HWDATA[plrp_pkg::CTRL_IRQ_BIT];
      rmii_sel_r <= HWDATA[plrp_pkg::CTRL_RMII_BIT];
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------

  // Zero wait states; read data staged during the address phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_ctrl_r <= 1'b0;
      hrdata_r <= 32'h00000000;
    end else begin
      if (HREADY) begin
        wr_pend_r <= wr_ph;
        wr_ctrl_r <= addr_is(HADDR, plrp_pkg::ADDR_CTRL);
        hrdata_r <= rd_nxt;
      end
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ----------------------------------------
  // Indicator outputs
  // ----------------------------------------

  // LEDs are active high: one means lit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_led_r <= 1'b0;
      speed_led_r <= 1'b0;
      actcol_led_r <= 1'b0;
    end else begin
      link_led_r <= link_nxt;
      speed_led_r <= SPEED_100;
      actcol_led_r <= actcol_nxt;
    end
  end

  assign LINK_INDICATOR = link_led_r;
  assign SPEED_INDICATOR = speed_led_r;
  assign ACTIVITY_COLLISION_INDICATOR = actcol_led_r;

  // ----------------------------------------
  // Shared pin and power-down
  // ----------------------------------------

  // Drive value is always low; the enable carries the interrupt
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pin_o_r <= 1'b0;
    end else begin
      pd_r <= pd_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_o_r <= 1'b0;
    end
  end

  assign POWER_DOWN = pd_r;
  assign POWERDOWN_IRQ_PIN_OE = pin_oe_r;
  assign POWERDOWN_IRQ_PIN_O = pin_o_r;

  // ----------------------------------------
  // Helper modules
  // ----------------------------------------

  // Reference clock output divider
  plrp_clkgen u_clkgen (
    .clk(CLK),
    .rst_n(RST_N),
    .lk(lk.clkgen)
  );

  assign REF_CLOCK_OUT = lk.ref_clk;

  // Link indicator blink engine
  plrp_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk(CLK),
    .rst_n(RST_N),
    .lk(lk.blink)
  );

endmodule
`default_nettype wire

// >>> bench/plrp_monitor.sv
`default_nettype none
module plrp_monitor #(
  parameter int BLINK_HALF_CYC = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  input wire logic COLLISION,
  input wire logic FULL_DUPLEX,
  input wire logic IRQ_REQ,
  input wire logic POWERDOWN_IRQ_PIN_I,
  input wire logic POWERDOWN_IRQ_PIN_O,
  input wire logic POWERDOWN_IRQ_PIN_OE,
  input wire logic POWER_DOWN,
  input wire logic REF_CLOCK_OUT,
  input wire logic LINK_INDICATOR,
  input wire logic SPEED_INDICATOR,
  input wire logic ACTIVITY_COLLISION_INDICATOR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic on_r; // Inside the dark phase of a blink
  logic [31:0] low_cnt_r; // Dark cycles seen so far
  // ----------------------------------------
  // Blink dark-phase counter
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_r <= 1'b0;
      low_cnt_r <= 32'h0;
    end else if (!LINK_UP || LINK_INDICATOR) begin
      on_r <= 1'b0;
      low_cnt_r <= 32'h0;
    end else if (on_r) begin
      low_cnt_r <= low_cnt_r + 32'h1;
    end else if ($past(LINK_INDICATOR)) begin
      on_r <= 1'b1;
      low_cnt_r <= 32'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_SPEED: assert property ($past(RST_N) |-> SPEED_INDICATOR == $past(SPEED_100))
    else $error("speed lamp off its input");
  AST_ACT: assert property (ACTIVITY_COLLISION_INDICATOR |->
    $past(TX_ACTIVE || RX_ACTIVE || COLLISION || FULL_DUPLEX))
    else $error("activity lamp lit without cause");
  AST_LINK: assert property (LINK_INDICATOR |-> $past(LINK_UP))
    else $error("link lamp lit without link");
  AST_BLINK: assert property ($rose(LINK_INDICATOR) && on_r |-> low_cnt_r == BLINK_HALF_CYC)
    else $error("blink dark phase of wrong length");
  AST_CLK_HI: assert property ($rose(REF_CLOCK_OUT) |-> REF_CLOCK_OUT[*2] ##[1:4] !REF_CLOCK_OUT)
    else $error("reference high phase wrong");
  AST_CLK_LO: assert property ($fell(REF_CLOCK_OUT) |-> !REF_CLOCK_OUT[*3] ##[1:3] REF_CLOCK_OUT)
    else $error("reference low phase wrong");
  AST_PD: assert property (POWER_DOWN |-> !$past(POWERDOWN_IRQ_PIN_I, 3))
    else $error("power-down without pin request");
  AST_OE: assert property (POWERDOWN_IRQ_PIN_OE |-> $past(IRQ_REQ))
    else $error("pin pulled low without request");
  AST_PIN0: assert property (!POWERDOWN_IRQ_PIN_O)
    else $error("open-drain pin drives high");
endmodule
bind plrp_top plrp_monitor #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) i_mon (.CLK, .RST_N, .LINK_UP,
  .SPEED_100, .TX_ACTIVE, .RX_ACTIVE, .COLLISION, .FULL_DUPLEX, .IRQ_REQ, .POWERDOWN_IRQ_PIN_I,
  .POWERDOWN_IRQ_PIN_O, .POWERDOWN_IRQ_PIN_OE, .POWER_DOWN, .REF_CLOCK_OUT, .LINK_INDICATOR,
  .SPEED_INDICATOR, .ACTIVITY_COLLISION_INDICATOR);
`default_nettype wire

// >>> bench/plrp_board.sv
`default_nettype none
// Board side of the shared pin: pull-up plus power controller
module plrp_board (
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pd_req,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-low: either party pulls down, otherwise the pull-up wins
  assign pin_level = ((pin_oe && !pin_o) || pd_req) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// >>> bench/phy_led_reset_powerdown_pins_tb.sv
`default_nettype none
module phy_led_reset_powerdown_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, link, spd, tx, rx, col, fdx, irq, s_rmii, pd_req;
  logic [1:0] htrans, s_mode;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hreadyout, hresp, pin_o, pin_oe, pin_lvl, pwr_dn, refck, led_lk, led_sp, led_ac;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int hi, lo, i;
  // ----------------------------------------
  // Clock, design and board
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  plrp_top #(.BLINK_HALF_CYC(8)) i_dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .LINK_UP(link), .SPEED_100(spd),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .COLLISION(col), .FULL_DUPLEX(fdx), .IRQ_REQ(irq),
    .STRAP_RMII(s_rmii), .STRAP_LED_MODE(s_mode), .POWERDOWN_IRQ_PIN_I(pin_lvl),
    .POWERDOWN_IRQ_PIN_O(pin_o), .POWERDOWN_IRQ_PIN_OE(pin_oe), .POWER_DOWN(pwr_dn),
    .REF_CLOCK_OUT(refck), .LINK_INDICATOR(led_lk), .SPEED_INDICATOR(led_sp),
    .ACTIVITY_COLLISION_INDICATOR(led_ac));
  plrp_board i_board (.pin_o(pin_o), .pin_oe(pin_oe), .pd_req(pd_req), .pin_level(pin_lvl));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // Reset with given strap levels, straps held well past the latch
  task automatic do_reset(input logic r, input logic [1:0] m);
    rst_n <= 1'b0;
    s_rmii <= r;
    s_mode <= m;
    tick(10);
    rst_n <= 1'b1;
    tick(8);
  endtask
  // Length of one high and one low phase of the reference output
  task automatic clkphase();
    hi = 0;
    lo = 0;
    for (i = 0; i < 20 && refck !== 1'b0; i++) @(posedge clk);
    for (i = 0; i < 20 && refck !== 1'b1; i++) @(posedge clk);
    while (refck === 1'b1 && hi < 20) begin
      hi++;
      @(posedge clk);
    end
    while (refck === 1'b0 && lo < 20) begin
      lo++;
      @(posedge clk);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hsel, hwrite, link, spd, tx, rx, col, fdx, irq, pd_req, s_rmii} = '0;
    rst_n = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    s_mode = 2'h1;
    haddr = 32'h0;
    hwdata = 32'h0;
    @(posedge clk);
    do_reset(1'b0, 2'h1);
    bus(1'b0, plrp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h00000001);
    bus(1'b0, plrp_pkg::ADDR_STRAP, 32'h0);
    chk(rd, 32'h00000001);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h00000000);
    clkphase();
    chk(32'(hi), 32'h5);
    chk(32'(lo), 32'h5);
    // Mode 1: steady link lamp, activity lamp, speed lamp
    link <= 1'b1;
    tx <= 1'b1;
    spd <= 1'b1;
    tick(2);
    chk(32'({led_lk, led_ac, led_sp}), 32'h7);
    tick(6);
    chk(32'(led_lk), 32'h1);
    spd <= 1'b0;
    tx <= 1'b0;
    rx <= 1'b1;
    tick(2);
    chk(32'({led_sp, led_ac}), 32'h1);
    rx <= 1'b0;
    tick(2);
    chk(32'(led_ac), 32'h0);
    // Mode 2: one blink per burst, collision shown
    bus(1'b1, plrp_pkg::ADDR_CTRL, 32'h2);
    tx <= 1'b1;
    @(posedge clk);
    tx <= 1'b0;
    for (i = 0; i < 12 && led_lk !== 1'b0; i++) @(posedge clk);
    for (hi = 0; hi < 20 && led_lk === 1'b0; hi++) @(posedge clk);
    chk(32'(hi), 32'h8);
    col <= 1'b1;
    tick(2);
    chk(32'(led_ac), 32'h1);
    col <= 1'b0;
    fdx <= 1'b1;
    tick(2);
    chk(32'(led_ac), 32'h0);
    // Mode 3: duplex chosen, then collision chosen
    bus(1'b1, plrp_pkg::ADDR_CTRL, 32'h7);
    tick(2);
    chk(32'(led_ac), 32'h1);
    fdx <= 1'b0;
    col <= 1'b1;
    tick(2);
    chk(32'(led_ac), 32'h0);
    bus(1'b1, plrp_pkg::ADDR_CTRL, 32'h3);
    tick(2);
    chk(32'(led_ac), 32'h1);
    col <= 1'b0;
    // Shared pin: power-down role, then interrupt role after a write
    irq <= 1'b1;
    pd_req <= 1'b1;
    tick(4);
    chk(32'({pwr_dn, pin_oe}), 32'h2);
    bus(1'b0, plrp_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h000000A1);
    chk(32'(hresp), 32'h0);
    pd_req <= 1'b0;
    tick(4);
    chk(32'(pwr_dn), 32'h0);
    bus(1'b1, plrp_pkg::ADDR_CTRL, 32'hB);
    tick(5);
    chk(32'({pin_oe, pin_o, pin_lvl, pwr_dn}), 32'h8);
    irq <= 1'b0;
    tick(2);
    chk(32'({pin_oe, pin_lvl}), 32'h1);
    // Second reset takes new straps and clears the role
    do_reset(1'b1, 2'h3);
    bus(1'b0, plrp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h00000013);
    bus(1'b0, plrp_pkg::ADDR_STRAP, 32'h0);
    chk(rd, 32'h00000007);
    clkphase();
    chk(32'(hi), 32'h2);
    chk(32'(lo), 32'h3);
    stop_test();
  end
endmodule
`default_nettype wire
